// *** bench/crs_blk_model.sv ***
`timescale 1ns/1ps
// Far-side blocks: ring oscillator edges and done signals
module crs_blk_model
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // From the sequencer
  input  wire logic       rosc_en,
  input  wire logic [8:0] blk_rst_n,
  // To the sequencer
  output logic            rosc_edge,
  output logic      [6:0] blk_done
);
  // Edge every other cycle, none while disabled
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      rosc_edge <= 1'b0;
    else
      rosc_edge <= rosc_en && !rosc_edge;
  // Done after a random stall, dropped one cycle after its reset falls
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      blk_done <= '0;
    else
      for (int i = 0; i < 7; i++)
        if (!blk_rst_n[i+2])
          blk_done[i] <= 1'b0;
        else if ($urandom_range(3) == 0)
          blk_done[i] <= 1'b1;
endmodule

// *** bench/crs_top_tb.sv ***
`timescale 1ns/1ps
module crs_top_tb;
  import crs_pkg::*;
  // Short oscillator count keeps the run brief
  localparam logic [7:0] EDGES = 8'h04;
  logic        CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic        POR_N, BOD_N, RUN, DP_RESTART, WDOG_FIRE, ROSC_EDGE;
  logic        ROSC_EN, RST_N_RUN, RST_N_DP, CORE0_RST_N, CORE1_RST_N;
  logic        REF_UNDIV, SYS_FROM_REF, er;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [3:0]  BOD_BROWNOUT_THRESHOLD_SELECT, brownout_threshold_select;
  logic [8:0]  BLK_RST_N, prev;
  logic [6:0]  BLK_DONE;
  int          failures, check_count, edges, n;

  crs_top #(.ROSC_EDGES(EDGES)) dut (.CLK(CLK), .NRST(NRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .POR_N(POR_N),
    .BOD_N(BOD_N), .RUN(RUN), .DP_RESTART(DP_RESTART),
    .WDOG_FIRE(WDOG_FIRE), .BOD_BROWNOUT_THRESHOLD_SELECT(BOD_BROWNOUT_THRESHOLD_SELECT), .ROSC_EN(ROSC_EN),
    .ROSC_EDGE(ROSC_EDGE), .RST_N_RUN(RST_N_RUN), .RST_N_DP(RST_N_DP),
    .BLK_RST_N(BLK_RST_N), .BLK_DONE(BLK_DONE), .CORE0_RST_N(CORE0_RST_N),
    .CORE1_RST_N(CORE1_RST_N), .REF_UNDIV(REF_UNDIV),
    .SYS_FROM_REF(SYS_FROM_REF));
  crs_blk_model blk (.clk(CLK), .nrst(NRST), .rosc_en(ROSC_EN),
    .blk_rst_n(BLK_RST_N), .rosc_edge(ROSC_EDGE), .blk_done(BLK_DONE));

  // Free-running system clock
  initial
  begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 50);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // Wait for the processor complex, bounded
  task automatic boot;
    int k;
    k = 0;
    while (BLK_RST_N[8] !== 1'b1 && k < 3000)
    begin
      @(posedge CLK);
      k++;
    end
    // Last stage's done is random; wait so the done read is settled
    while (BLK_DONE[6] !== 1'b1 && k < 3000)
    begin
      @(posedge CLK);
      k++;
    end
    chk("boot", {ROSC_EN, CORE0_RST_N, CORE1_RST_N, RST_N_RUN, RST_N_DP,
        REF_UNDIV, SYS_FROM_REF}, 7'h7f);
  endtask

  // Release order watcher: each stage needs its predecessor done
  always @(posedge CLK)
  begin
    if (!BLK_RST_N[0])
      edges <= 0;
    else if (ROSC_EDGE)
      edges <= edges + 1;
    for (int i = 1; i < 9; i++)
      if (NRST && BLK_RST_N[i] && !prev[i])
      begin
        chk("order", prev[i-1], 1'b1);
        if (i == 1)
          chk("rosc", edges >= EDGES, 1'b1);
        if (i > 2)
          chk("done", BLK_DONE[i-3], 1'b1);
      end
    prev <= BLK_RST_N;
  end

  // Hang guard
  initial
  begin
    #(20000 * 20);
    failures++;
    test_done;
  end

  initial
  begin
    void'($urandom(32'h385a));
    {NRST, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    {POR_N, BOD_N, RUN, DP_RESTART, WDOG_FIRE} = '0;
    prev = '0;
    repeat (12) @(posedge CLK);
    chk("brownout_threshold_select", BOD_BROWNOUT_THRESHOLD_SELECT, CRS_BROWNOUT_THRESHOLD_SELECT_RESET);
    chk("clkcfg", {REF_UNDIV, SYS_FROM_REF}, 2'b11);
    NRST <= 1'b1;
    {POR_N, BOD_N, RUN} <= 3'b111;
    boot;
    apb(1'b0, CRS_CHIP_STAT_OFS, 32'h0);
    chk("cause", rd, 32'h1);
    apb(1'b0, CRS_DONE_OFS, 32'h0);
    chk("donereg", rd, 32'h1ff);
    apb(1'b1, 12'h020, 32'hffff_ffff);
    chk("unmapped", er, 1'b1);
    // Threshold change lands only after the programming delay
    brownout_threshold_select = 4'(CRS_BROWNOUT_THRESHOLD_SELECT_RESET + 1 + $urandom_range(14));
    apb(1'b1, CRS_BOD_CTRL_OFS, {28'h0, brownout_threshold_select});
    repeat (CRS_PROG_CYCLES - 20) @(posedge CLK);
    chk("brownout_threshold_select_early", BOD_BROWNOUT_THRESHOLD_SELECT, CRS_BROWNOUT_THRESHOLD_SELECT_RESET);
    repeat (40) @(posedge CLK);
    chk("brownout_threshold_select_late", BOD_BROWNOUT_THRESHOLD_SELECT, brownout_threshold_select);
    // Watchdog on stage 5 cascades to later stages only
    apb(1'b1, CRS_WDOG_SEL_OFS, 32'h20);
    WDOG_FIRE <= 1'b1;
    @(posedge CLK);
    WDOG_FIRE <= 1'b0;
    n = 0;
    while (BLK_RST_N[8] !== 1'b0 && n < 20)
    begin
      @(posedge CLK);
      n++;
    end
    chk("wdog", {RST_N_RUN, BLK_RST_N[8], BLK_RST_N[4:0]}, 7'h5f);
    boot;
    apb(1'b0, CRS_CHIP_STAT_OFS, 32'h0);
    chk("keep", rd, 32'h1);
    // Debug restart: sequencer only, flag set
    DP_RESTART <= 1'b1;
    repeat (5) @(posedge CLK);
    chk("dp", {RST_N_RUN, RST_N_DP, BLK_RST_N}, 11'h600);
    chk("brownout_threshold_select_dp", BOD_BROWNOUT_THRESHOLD_SELECT, CRS_BROWNOUT_THRESHOLD_SELECT_RESET);
    DP_RESTART <= 1'b0;
    boot;
    apb(1'b0, CRS_CHIP_STAT_OFS, 32'h0);
    chk("dpcause", rd, 32'h104);
    // Run pin, brown-out, power-on in turn
    for (int k = 0; k < 3; k++)
    begin
      {POR_N, BOD_N, RUN} <= ~(3'b001 << k);
      repeat (3 + $urandom_range(7)) @(posedge CLK);
      chk("held", {RST_N_RUN, RST_N_DP, BLK_RST_N}, 11'h0);
      {POR_N, BOD_N, RUN} <= 3'b111;
      repeat (2) @(posedge CLK);
      chk("freed", RST_N_RUN, 1'b1);
      boot;
      apb(1'b0, CRS_CHIP_STAT_OFS, 32'h0);
      chk("src", rd, (k == 0) ? 32'h2 : 32'h1);
    end
    // Debugger sets the restart flag by a plain write
    apb(1'b1, CRS_CHIP_STAT_OFS, 32'h100);
    apb(1'b0, CRS_CHIP_STAT_OFS, 32'h0);
    chk("swflag", rd, 32'h101);
    test_done;
  end
endmodule

// *** core/crs_pkg.sv ***
package crs_pkg;
  // APB map, byte addresses
  localparam logic [11:0] CRS_BOD_CTRL_OFS  = 12'h000;
  localparam logic [11:0] CRS_CHIP_STAT_OFS = 12'h004;
  localparam logic [11:0] CRS_WDOG_SEL_OFS  = 12'h008;
  localparam logic [11:0] CRS_DONE_OFS      = 12'h00c;
  localparam logic [11:0] CRS_CLK_CFG_OFS   = 12'h010;
  // Chip status field positions
  localparam int CRS_LAST_POWER_BIT = 0;
  localparam int CRS_LAST_RUN_BIT   = 1;
  localparam int CRS_LAST_DEBUG_BIT = 2;
  localparam int CRS_RESTART_BIT    = 8;
  // Clock config field positions
  localparam int CRS_REF_UNDIV_BIT  = 0;
  localparam int CRS_SYS_REF_BIT    = 1;
  // Sequencer stages in release order
  localparam int CRS_STAGES    = 9;
  localparam int CRS_ST_ROSC   = 0;
  localparam int CRS_ST_XOSC   = 1;
  localparam int CRS_ST_CLOCKS = 2;
  localparam int CRS_ST_PROC   = 8;
  // Threshold select code for nominal 0.86 V
  localparam logic [3:0] CRS_BROWNOUT_THRESHOLD_SELECT_RESET = 4'h9;
  // Threshold programming delay, typical figure
  localparam int CRS_CLK_MHZ      = 50;
  localparam int CRS_T_PROG_US    = 20;
  localparam int CRS_PROG_CYCLES  = CRS_T_PROG_US * CRS_CLK_MHZ;
  localparam logic [10:0] CRS_PROG_LOAD = 11'(CRS_PROG_CYCLES);
  // Oscillator edges counted before it counts as stable
  localparam logic [7:0] CRS_ROSC_EDGES = 8'h40;
  // Oscillator stage states, Gray along the path
  typedef enum logic [1:0]
  {
    CRS_ROSC_OFF    = 2'b00,
    CRS_ROSC_COUNT  = 2'b01,
    CRS_ROSC_STABLE = 2'b11
  } crs_rosc_t;
endpackage

// *** core/crs_top.sv ***
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
// Behaviour
// RULE1: threshold select returns to default on reset
// RULE2: new threshold applies after programming delay
// RULE3: run pin low holds chip in reset
// RULE4: release when run high and sources clear
// RULE5: debug restart resets chip, sets restart flag
// RULE6: record power, run or debug reset cause
// RULE7: at most one cause bit set
// RULE8: release one block, wait done, next
// RULE9: sequencer and run reset leave together
// RULE10: run reset not reasserted on restart
// RULE11: ring oscillator stage done after edge count
// RULE12: crystal stage done at once, not started
// RULE13: clocks released, ref undivided, sys from ref
// RULE14: fixed release order through processor complex
// RULE15: status reset only by chip-level reset
// RULE16: debugger may set restart flag itself
// RULE17: both cores released in final stage
// RULE18: debug restart spares the debug port
// RULE19: brown-out reinitialises power-on reset
// RULE20: watchdog reset cascades to later blocks
// RULE21: edge count is a design parameter
module crs_top
  import crs_pkg::*;
#(
  parameter logic [7:0] ROSC_EDGES = crs_pkg::CRS_ROSC_EDGES
)
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        NRST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Reset sources
  input  wire logic        POR_N,
  input  wire logic        BOD_N,
  input  wire logic        RUN,
  input  wire logic        DP_RESTART,
  input  wire logic        WDOG_FIRE,
  // Detector and oscillator
  output logic      [3:0]  BOD_BROWNOUT_THRESHOLD_SELECT,
  output logic             ROSC_EN,
  input  wire logic        ROSC_EDGE,
  // Block resets for stages 0 to 8, done signals for stages 2 to 8
  output logic             RST_N_RUN,
  output logic             RST_N_DP,
  output logic      [8:0]  BLK_RST_N,
  input  wire logic [6:0]  BLK_DONE,
  output logic             CORE0_RST_N,
  output logic             CORE1_RST_N,
  output logic             REF_UNDIV,
  output logic             SYS_FROM_REF
);
  import crs_pkg::*;

  logic            chip_ok_next;
  logic            seq_ok_next;
  logic            seq_ok_reg;
  logic [2:0]      last_reg;
  logic            restart_reg;
  logic [3:0]      brownout_threshold_select_reg;
  logic [10:0]     prog_cnt_reg;
  logic [8:0]      watchdog_reset_select_reg;
  logic [8:0]      rst_next;
  logic [8:0]      done_eff;
  logic [7:0]      rosc_cnt_reg;
  crs_rosc_t       rosc_state_reg;
  logic            rosc_done;
  logic            apb_setup;
  logic            apb_wr;
  logic            hit;
  logic [31:0]     rd_next;

  // Brown-out pulls the power-on output down with it
  assign chip_ok_next = POR_N & BOD_N & RUN; // RULE3 RULE19
  // Debug restart holds only the sequencer side
  assign seq_ok_next  = chip_ok_next & ~DP_RESTART; // RULE18

  // Chip-level reset outputs, run level ignores restarts
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      RST_N_RUN  <= 1'b0;
      RST_N_DP   <= 1'b0;
      seq_ok_reg <= 1'b0;
    end
    else
    begin
      RST_N_RUN  <= chip_ok_next; // RULE4 RULE9 RULE10
      RST_N_DP   <= chip_ok_next; // RULE18
      seq_ok_reg <= seq_ok_next; // RULE4 RULE9
    end
  end

  // Bus phases; zero wait states, answer in first access cycle
  assign apb_setup = PSEL & ~PENABLE;
  assign apb_wr    = PSEL & PENABLE & PREADY & PWRITE;
  assign hit = (PADDR == CRS_BOD_CTRL_OFS) || (PADDR == CRS_CHIP_STAT_OFS)
            || (PADDR == CRS_WDOG_SEL_OFS) || (PADDR == CRS_DONE_OFS)
            || (PADDR == CRS_CLK_CFG_OFS);

  // Cause record; power outranks run outranks debug
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      last_reg    <= 3'h1;
      restart_reg <= 1'b0;
    end
    // Chip-level reset restores the flag's reset value
    else if (!(POR_N & BOD_N))
    begin
      last_reg    <= 3'h1 << CRS_LAST_POWER_BIT; // RULE6 RULE7
      restart_reg <= 1'b0; // RULE15
    end
    else if (!RUN)
    begin
      last_reg    <= 3'h1 << CRS_LAST_RUN_BIT; // RULE6
      restart_reg <= 1'b0; // RULE15
    end
    else if (DP_RESTART)
    begin
      last_reg    <= 3'h1 << CRS_LAST_DEBUG_BIT; // RULE6
      restart_reg <= 1'b1; // RULE5
    end
    // Set beats clear; sequencer resets never touch this
    else if (apb_wr && PADDR == CRS_CHIP_STAT_OFS)
      restart_reg <= PWDATA[CRS_RESTART_BIT]; // RULE15 RULE16
  end

  // Threshold select, back to default whenever the sequencer side is held in reset
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      brownout_threshold_select_reg <= CRS_BROWNOUT_THRESHOLD_SELECT_RESET;
    else if (!seq_ok_reg)
      brownout_threshold_select_reg <= CRS_BROWNOUT_THRESHOLD_SELECT_RESET; // RULE1
    else if (apb_wr && PADDR == CRS_BOD_CTRL_OFS)
      brownout_threshold_select_reg <= PWDATA[3:0];
  end

  // Applied threshold lags the write by the programming delay
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      BOD_BROWNOUT_THRESHOLD_SELECT     <= CRS_BROWNOUT_THRESHOLD_SELECT_RESET;
      prog_cnt_reg <= 11'h000;
    end
    else if (!seq_ok_reg)
    begin
      BOD_BROWNOUT_THRESHOLD_SELECT     <= CRS_BROWNOUT_THRESHOLD_SELECT_RESET; // RULE1
      prog_cnt_reg <= 11'h000;
    end
    else if (apb_wr && PADDR == CRS_BOD_CTRL_OFS)
      prog_cnt_reg <= CRS_PROG_LOAD; // RULE2
    else if (prog_cnt_reg == 11'h001)
    begin
      BOD_BROWNOUT_THRESHOLD_SELECT     <= brownout_threshold_select_reg; // RULE2
      prog_cnt_reg <= 11'h000;
    end
    else if (prog_cnt_reg != 11'h000)
      prog_cnt_reg <= prog_cnt_reg - 11'h001;
  end

  // Watchdog selection, persists across restarts
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      watchdog_reset_select_reg <= 9'h000;
    else if (!RST_N_RUN)
      watchdog_reset_select_reg <= 9'h000;
    else if (apb_wr && PADDR == CRS_WDOG_SEL_OFS)
      watchdog_reset_select_reg <= PWDATA[8:0];
  end

  // Ring oscillator stage: start, then count its edges
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      rosc_state_reg <= CRS_ROSC_OFF;
      rosc_cnt_reg   <= 8'h00;
      ROSC_EN        <= 1'b0;
    end
    else
    begin
      ROSC_EN <= rst_next[CRS_ST_ROSC]; // RULE11
      case (rosc_state_reg)
        CRS_ROSC_OFF:
        begin
          rosc_cnt_reg <= 8'h00;
          if (BLK_RST_N[CRS_ST_ROSC])
            rosc_state_reg <= CRS_ROSC_COUNT;
        end
        CRS_ROSC_COUNT:
        begin
          if (!BLK_RST_N[CRS_ST_ROSC])
            rosc_state_reg <= CRS_ROSC_OFF;
          else if (rosc_cnt_reg == ROSC_EDGES)
            rosc_state_reg <= CRS_ROSC_STABLE; // RULE11 RULE21
          else if (ROSC_EDGE)
            rosc_cnt_reg <= rosc_cnt_reg + 8'h01;
        end
        CRS_ROSC_STABLE:
          if (!BLK_RST_N[CRS_ST_ROSC])
            rosc_state_reg <= CRS_ROSC_OFF;
        default:
          rosc_state_reg <= CRS_ROSC_OFF;
      endcase
    end
  end
  assign rosc_done = (rosc_state_reg == CRS_ROSC_STABLE);

  // Done is masked by own reset so a drop cascades at once
  assign done_eff = {BLK_DONE & BLK_RST_N[8:2],
                     BLK_RST_N[CRS_ST_XOSC], // RULE12
                     rosc_done};

  // Release chain: each stage waits for the one before
  always_comb
  begin
    rst_next[0] = seq_ok_reg & ~(WDOG_FIRE & watchdog_reset_select_reg[0]);
    for (int i = 1; i < CRS_STAGES; i++)
      rst_next[i] = seq_ok_reg & BLK_RST_N[i-1] & done_eff[i-1]
                  & ~(WDOG_FIRE & watchdog_reset_select_reg[i]); // RULE8 RULE14 RULE20
  end

  // Block resets and both cores from the final stage
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      BLK_RST_N   <= 9'h000;
      CORE0_RST_N <= 1'b0;
      CORE1_RST_N <= 1'b0;
    end
    else
    begin
      BLK_RST_N   <= rst_next; // RULE8 RULE14
      CORE0_RST_N <= rst_next[CRS_ST_PROC]; // RULE17
      CORE1_RST_N <= rst_next[CRS_ST_PROC]; // RULE17
    end
  end

  // Clock generators come up with ref undivided, sys on ref
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      REF_UNDIV    <= 1'b1;
      SYS_FROM_REF <= 1'b1;
    end
    else if (!BLK_RST_N[CRS_ST_CLOCKS])
    begin
      REF_UNDIV    <= 1'b1; // RULE13
      SYS_FROM_REF <= 1'b1; // RULE13
    end
    else if (apb_wr && PADDR == CRS_CLK_CFG_OFS)
    begin
      REF_UNDIV    <= PWDATA[CRS_REF_UNDIV_BIT];
      SYS_FROM_REF <= PWDATA[CRS_SYS_REF_BIT];
    end
  end

  // Read mux
  always_comb
  begin
    rd_next = 32'h0000_0000;
    case (PADDR)
      CRS_BOD_CTRL_OFS:  rd_next[3:0] = brownout_threshold_select_reg;
      CRS_CHIP_STAT_OFS:
      begin
        rd_next[2:0]             = last_reg;
        rd_next[CRS_RESTART_BIT] = restart_reg;
      end
      CRS_WDOG_SEL_OFS:  rd_next[8:0] = watchdog_reset_select_reg;
      CRS_DONE_OFS:      rd_next[8:0] = done_eff;
      CRS_CLK_CFG_OFS:
      begin
        rd_next[CRS_REF_UNDIV_BIT] = REF_UNDIV;
        rd_next[CRS_SYS_REF_BIT]   = SYS_FROM_REF;
      end
      default:           rd_next = 32'h0000_0000;
    endcase
  end

  // Answer registered in setup, stands for the access cycle
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end
    else
    begin
      PREADY  <= apb_setup;
      PSLVERR <= apb_setup & ~hit;
      PRDATA  <= apb_setup ? rd_next : 32'h0000_0000;
    end
  end

  sequence s_dbg_req;
    chip_ok_next && DP_RESTART;
  endsequence
  sequence s_dbg_effect;
    restart_reg && !seq_ok_reg && RST_N_RUN && last_reg[CRS_LAST_DEBUG_BIT];
  endsequence

  chk_brownout_threshold_select_default: assert property (@(posedge CLK) disable iff (!NRST) // RULE1
    !seq_ok_reg |=> brownout_threshold_select_reg == CRS_BROWNOUT_THRESHOLD_SELECT_RESET && BOD_BROWNOUT_THRESHOLD_SELECT == CRS_BROWNOUT_THRESHOLD_SELECT_RESET)
    else $error("threshold select not back at default");
  chk_prog_hold: assert property (@(posedge CLK) disable iff (!NRST) // RULE2
    (seq_ok_reg && prog_cnt_reg > 11'h001) |=> $stable(BOD_BROWNOUT_THRESHOLD_SELECT))
    else $error("threshold applied before programming delay");
  chk_run_low: assert property (@(posedge CLK) disable iff (!NRST) // RULE3
    !RUN |=> !RST_N_RUN && !seq_ok_reg ##1 BLK_RST_N == 9'h000)
    else $error("run low did not hold reset");
  chk_run_release: assert property (@(posedge CLK) disable iff (!NRST) // RULE4
    seq_ok_next |=> RST_N_RUN && seq_ok_reg)
    else $error("reset not released with run high");
  chk_dbg_restart: assert property (@(posedge CLK) disable iff (!NRST) // RULE5
    s_dbg_req |=> s_dbg_effect)
    else $error("debug restart effect missing");
  chk_cause_onehot: assert property (@(posedge CLK) disable iff (!NRST) // RULE7
    $onehot0(last_reg))
    else $error("more than one reset cause set");
  chk_chain_order: assert property (@(posedge CLK) disable iff (!NRST) // RULE8
    (BLK_RST_N[8:1] & ~$past(BLK_RST_N[7:0] & done_eff[7:0])) == 8'h00)
    else $error("block released before previous done");
  chk_rosc_count: assert property (@(posedge CLK) disable iff (!NRST) // RULE11
    $rose(rosc_done) |-> $past(rosc_cnt_reg) == ROSC_EDGES)
    else $error("oscillator done before edge count");
  chk_run_kept: assert property (@(posedge CLK) disable iff (!NRST) // RULE10
    (RST_N_RUN && chip_ok_next) |=> RST_N_RUN)
    else $error("run reset reasserted on restart");
  chk_cores_pair: assert property (@(posedge CLK) disable iff (!NRST) // RULE17
    CORE0_RST_N == CORE1_RST_N && CORE0_RST_N == BLK_RST_N[CRS_ST_PROC])
    else $error("cores not released together");
  chk_wdog_cascade: assert property (@(posedge CLK) disable iff (!NRST) // RULE20
    (WDOG_FIRE && watchdog_reset_select_reg != 9'h000) |=> (BLK_RST_N & $past(watchdog_reset_select_reg)) == 9'h000
      ##1 (BLK_RST_N[8:1] & $past(watchdog_reset_select_reg[7:0], 2)) == 8'h00)
    else $error("watchdog reset did not cascade");
endmodule
